/* cmpc_map.svh */
`ifndef CMPC_MAP_SVH
`define CMPC_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CMPC_OFS_CTRL1 8'h00
`define CMPC_OFS_CTRL2 8'h04
`define CMPC_OFS_RESULT 8'h08
`define CMPC_OFS_FLAG 8'h0C
`define CMPC_OFS_ENABLE 8'h10
`define CMPC_OFS_IRQCTL 8'h14
`define CMPC_OFS_PDIR 8'h18
`define CMPC_OFS_PLAT 8'h1C
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CMPC_CTL_ENABLE 7
`define CMPC_CTL_PIN_OE 6
`define CMPC_CTL_INVERT 5
`define CMPC_CTL_EDGE_HI 4
`define CMPC_CTL_EDGE_LO 3
`define CMPC_CTL_PLUS 2
`define CMPC_CTL_MINUS_HI 1
`define CMPC_CTL_MINUS_LO 0
`define CMPC_CTL_RESET 8'h1F
// ----------------------------------------
// Flag, enable, irq control and port fields
// ----------------------------------------
`define CMPC_FLAG_LO 5
`define CMPC_FLAG_HI 6
`define CMPC_IRQ_PERIPH 6
`define CMPC_IRQ_GLOBAL 7
`define CMPC_PORT_LO 1
`define CMPC_PORT_HI 2
`define CMPC_PDIR_RESET 2'h3
// ----------------------------------------
// Encodings
// ----------------------------------------
`define CMPC_EDGE_NONE 2'h0
`define CMPC_EDGE_RISE 2'h1
`define CMPC_EDGE_FALL 2'h2
`define CMPC_EDGE_ANY 2'h3
`define CMPC_MINUS_B 2'h0
`define CMPC_MINUS_C 2'h1
`define CMPC_MINUS_D 2'h2
`define CMPC_MINUS_FIXREF 2'h3
`endif

/* cmpc_pkg.sv */
package cmpc_pkg;
  typedef logic [7:0] cmpc_ctrl_t;
  typedef logic [1:0] cmpc_edge_t;
  typedef enum logic [1:0] {CMPC_BUS_IDLE, CMPC_BUS_WRITE, CMPC_BUS_READ} cmpc_bus_e;
endpackage

/* cmpc_edge.sv */
`timescale 1ns/1ps
`include "cmpc_map.svh"
module cmpc_edge (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_raw,
  input wire logic i_enable,
  input wire logic i_invert,
  input wire cmpc_pkg::cmpc_edge_t i_edge_sel,
  output logic o_level,
  output logic o_event
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic en_d_r;
  logic level;
  logic rise;
  logic fall;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      sync1_r <= i_raw;
      sync2_r <= sync1_r;
    end
  end

  // Polarity-adjusted level; off comparator reads low
  assign level = i_enable & (sync2_r ^ i_invert);
  assign o_level = level;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      prev_r <= 1'b0;
      en_d_r <= 1'b0;
    end
    else
    begin
      prev_r <= level;
      en_d_r <= i_enable;
    end
  end

  // Quiet while disabled, and on the enable/disable edge itself
  assign rise = i_enable & en_d_r & level & ~prev_r;
  assign fall = i_enable & en_d_r & ~level & prev_r;

  always_comb
  begin
    case (i_edge_sel)
      `CMPC_EDGE_NONE: o_event = 1'b0;
      `CMPC_EDGE_RISE: o_event = rise;
      `CMPC_EDGE_FALL: o_event = fall;
      `CMPC_EDGE_ANY: o_event = rise | fall;
      default: o_event = 1'b0;
    endcase
  end
endmodule

/* cmpc_ahb.sv */
`timescale 1ns/1ps
module cmpc_ahb (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] i_rdata,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_wr_en,
  output logic [7:0] o_addr
);
  cmpc_pkg::cmpc_bus_e phase_r;
  logic [7:0] addr_r;
  logic take;

  assign take = i_hsel & i_htrans[1] & i_hready;
  assign o_addr = addr_r;
  assign o_wr_en = (phase_r == cmpc_pkg::CMPC_BUS_WRITE);

  // ----------------------------------------
  // Address phase capture
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      phase_r <= cmpc_pkg::CMPC_BUS_IDLE;
      addr_r <= 8'h00;
    end
    else if (take)
    begin
      phase_r <= i_hwrite ? cmpc_pkg::CMPC_BUS_WRITE : cmpc_pkg::CMPC_BUS_READ;
      addr_r <= i_haddr[7:0];
    end
    else
      phase_r <= cmpc_pkg::CMPC_BUS_IDLE;
  end

  // ----------------------------------------
  // Reads take one wait state so prior writes land first
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_hreadyout <= 1'b1;
      o_hrdata <= 32'h0000_0000;
    end
    else if (take && !i_hwrite)
      o_hreadyout <= 1'b0;
    else if (phase_r == cmpc_pkg::CMPC_BUS_READ)
    begin
      o_hreadyout <= 1'b1;
      o_hrdata <= i_rdata;
    end
  end
endmodule

/* cmpc_top.sv */
// How it works
// - A comparator runs only while its enable bit 7 is one.
// - Bits 1:0 pick one of three pins or fixed reference for minus input.
// - Minus select 11 fixed ref, 10 pin D, 01 pin C, 00 pin B.
// - Bit 2 zero takes plus pin A, one takes programmable reference.
// - Result register bits 0 and 1 show comparator outputs; writes ignored.
// - Pin output enable bit 6 routes comparator result to its port pin.
// - Port direction bits still drive the pin output enable.
// - Result high when plus exceeds minus; bit 5 inverts it.
// - Edge select bits 4:3 choose which output transitions set the flag.
// - Edge 01 sets on rising, 10 on falling; flag sticks until cleared.
// - Edge 11 sets the flag on any output change.
// - Edge 00 never sets the flag from transitions.
// - Newly selecting any-change mode sets the flag once.
// - Flag bits 6:5 clear on written zero, set on written one.
// - Interrupt needs flag enable, peripheral enable and global enable.
// - Flags set regardless of interrupt enables.
// - Pins C and D exist only in the large package; pin D not for comparator 1.
// - Reset returns both control registers to defaults, comparators off.
`timescale 1ns/1ps
`include "cmpc_map.svh"
module cmpc_top (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_large_package,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  input wire logic i_cmp1_raw,
  input wire logic i_cmp2_raw,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  output logic o_cmp1_power,
  output logic o_cmp2_power,
  output logic o_cmp1_plus_sel,
  output logic o_cmp2_plus_sel,
  output logic [3:0] o_cmp1_minus_onehot,
  output logic [3:0] o_cmp2_minus_onehot,
  output logic o_pin_f1_out,
  output logic o_pin_f1_oe,
  output logic o_pin_f2_out,
  output logic o_pin_f2_oe,
  output logic o_irq
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  cmpc_pkg::cmpc_ctrl_t ctrl_r [1:0];
  logic [1:0] flag_r;
  logic [1:0] flag_nxt;
  logic [1:0] irq_en_r;
  logic periph_en_r;
  logic global_en_r;
  logic [1:0] pdir_r;
  logic [1:0] plat_r;
  logic [1:0] chan_ok;
  logic [1:0] level;
  logic [1:0] event_hit;
  logic [1:0] any_mode_new;
  logic [1:0] raw;
  logic wr_en;
  logic [7:0] addr;
  logic [31:0] rdata;

  assign raw = {i_cmp2_raw, i_cmp1_raw};
  assign o_hresp = 1'b0;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  cmpc_ahb u_ahb (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hready(i_hready),
    .i_rdata(rdata),
    .o_hreadyout(o_hreadyout),
    .o_hrdata(o_hrdata),
    .o_wr_en(wr_en),
    .o_addr(addr)
  );

  // ----------------------------------------
  // Per-comparator control, channel check and edge logic
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_cmp
      logic [7:0] ofs;
      logic [1:0] minus;
      logic [1:0] edge_sel;
      logic ok;
      logic en;

      assign ofs = (g == 0) ? `CMPC_OFS_CTRL1 : `CMPC_OFS_CTRL2;
      assign minus = ctrl_r[g][`CMPC_CTL_MINUS_HI:`CMPC_CTL_MINUS_LO];
      assign edge_sel = ctrl_r[g][`CMPC_CTL_EDGE_HI:`CMPC_CTL_EDGE_LO];

      // Channels C and D only on the large package, D never on comparator 1
      always_comb
      begin
        case (minus)
          `CMPC_MINUS_B: ok = 1'b1;
          `CMPC_MINUS_C: ok = i_large_package;
          `CMPC_MINUS_D: ok = i_large_package & (g == 1);
          `CMPC_MINUS_FIXREF: ok = 1'b1;
          default: ok = 1'b0;
        endcase
      end

      assign chan_ok[g] = ok;

      assign en = ctrl_r[g][`CMPC_CTL_ENABLE] & chan_ok[g];

      // Writing 11 over any other edge mode raises the flag
      assign any_mode_new[g] = wr_en && (addr == ofs)
        && (i_hwdata[`CMPC_CTL_EDGE_HI:`CMPC_CTL_EDGE_LO] == `CMPC_EDGE_ANY)
        && (edge_sel != `CMPC_EDGE_ANY);

      always_ff @(posedge i_clk)
      begin
        if (i_sys_rst)
          ctrl_r[g] <= `CMPC_CTL_RESET;
        else if (wr_en && addr == ofs)
          ctrl_r[g] <= i_hwdata[7:0];
      end

      cmpc_edge u_edge (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_raw(raw[g]),
        .i_enable(en),
        .i_invert(ctrl_r[g][`CMPC_CTL_INVERT]),
        .i_edge_sel(edge_sel),
        .o_level(level[g]),
        .o_event(event_hit[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Analog steering outputs
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_cmp1_power <= 1'b0;
      o_cmp2_power <= 1'b0;
      o_cmp1_plus_sel <= 1'b0;
      o_cmp2_plus_sel <= 1'b0;
      o_cmp1_minus_onehot <= 4'h0;
      o_cmp2_minus_onehot <= 4'h0;
    end
    else
    begin
      o_cmp1_power <= ctrl_r[0][`CMPC_CTL_ENABLE] & chan_ok[0];
      o_cmp2_power <= ctrl_r[1][`CMPC_CTL_ENABLE] & chan_ok[1];
      o_cmp1_plus_sel <= ctrl_r[0][`CMPC_CTL_PLUS];
      o_cmp2_plus_sel <= ctrl_r[1][`CMPC_CTL_PLUS];
      // Bit 0 pin B, 1 pin C, 2 pin D, 3 fixed reference
      o_cmp1_minus_onehot <= chan_ok[0]
        ? 4'h1 << ctrl_r[0][`CMPC_CTL_MINUS_HI:`CMPC_CTL_MINUS_LO] : 4'h0;
      o_cmp2_minus_onehot <= chan_ok[1]
        ? 4'h1 << ctrl_r[1][`CMPC_CTL_MINUS_HI:`CMPC_CTL_MINUS_LO] : 4'h0;
    end
  end

  // ----------------------------------------
  // Port pins
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      pdir_r <= `CMPC_PDIR_RESET;
      plat_r <= 2'h0;
    end
    else if (wr_en)
    begin
      if (addr == `CMPC_OFS_PDIR)
        pdir_r <= i_hwdata[`CMPC_PORT_HI:`CMPC_PORT_LO];
      if (addr == `CMPC_OFS_PLAT)
        plat_r <= i_hwdata[`CMPC_PORT_HI:`CMPC_PORT_LO];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_pin_f1_out <= 1'b0;
      o_pin_f2_out <= 1'b0;
      o_pin_f1_oe <= 1'b0;
      o_pin_f2_oe <= 1'b0;
    end
    else
    begin
      o_pin_f1_out <= ctrl_r[0][`CMPC_CTL_PIN_OE] ? level[0] : plat_r[0];
      o_pin_f2_out <= ctrl_r[1][`CMPC_CTL_PIN_OE] ? level[1] : plat_r[1];
      o_pin_f1_oe <= ~pdir_r[0];
      o_pin_f2_oe <= ~pdir_r[1];
    end
  end

  // ----------------------------------------
  // Event flags: hardware set wins over a written zero
  // ----------------------------------------
  always_comb
  begin
    flag_nxt = flag_r;
    if (wr_en && addr == `CMPC_OFS_FLAG)
      flag_nxt = i_hwdata[`CMPC_FLAG_HI:`CMPC_FLAG_LO];
    flag_nxt = flag_nxt | event_hit | any_mode_new;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      flag_r <= 2'h0;
    else
      flag_r <= flag_nxt;
  end

  // ----------------------------------------
  // Interrupt enables and request
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      irq_en_r <= 2'h0;
      periph_en_r <= 1'b0;
      global_en_r <= 1'b0;
    end
    else if (wr_en)
    begin
      if (addr == `CMPC_OFS_ENABLE)
        irq_en_r <= i_hwdata[`CMPC_FLAG_HI:`CMPC_FLAG_LO];
      if (addr == `CMPC_OFS_IRQCTL)
      begin
        periph_en_r <= i_hwdata[`CMPC_IRQ_PERIPH];
        global_en_r <= i_hwdata[`CMPC_IRQ_GLOBAL];
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_irq <= 1'b0;
    else
      o_irq <= (|(flag_r & irq_en_r)) & periph_en_r & global_en_r;
  end

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  always_comb
  begin
    rdata = 32'h0000_0000;
    case (addr)
      `CMPC_OFS_CTRL1: rdata[7:0] = ctrl_r[0];
      `CMPC_OFS_CTRL2: rdata[7:0] = ctrl_r[1];
      `CMPC_OFS_RESULT: rdata[1:0] = level;
      `CMPC_OFS_FLAG: rdata[`CMPC_FLAG_HI:`CMPC_FLAG_LO] = flag_r;
      `CMPC_OFS_ENABLE: rdata[`CMPC_FLAG_HI:`CMPC_FLAG_LO] = irq_en_r;
      `CMPC_OFS_IRQCTL: rdata[`CMPC_IRQ_GLOBAL:`CMPC_IRQ_PERIPH] = {global_en_r, periph_en_r};
      `CMPC_OFS_PDIR: rdata[`CMPC_PORT_HI:`CMPC_PORT_LO] = pdir_r;
      `CMPC_OFS_PLAT: rdata[`CMPC_PORT_HI:`CMPC_PORT_LO] = plat_r;
      default: rdata = 32'h0000_0000;
    endcase
  end
endmodule

/* cmpc_checker.sv */
`timescale 1ns/1ps
module cmpc_checker (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_large_package,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic o_cmp1_power,
  input wire logic o_cmp2_power,
  input wire logic [3:0] o_cmp1_minus_onehot,
  input wire logic [3:0] o_cmp2_minus_onehot,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------
  // Taken transfers
  // ----------------------------------------
  logic rd_take;
  logic wr_take;
  assign rd_take = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
  assign wr_take = i_hsel && i_htrans[1] && i_hready && i_hwrite;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  reset_clear_a: assert property ($past(i_sys_rst) |-> o_hreadyout && !o_cmp1_power && !o_cmp2_power && !o_irq)
    else $error("outputs not cleared by reset");
  rd_wait_a: assert property (rd_take |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state wrong");
  wr_nowait_a: assert property (wr_take |=> o_hreadyout)
    else $error("write stalled");
  rdata_hold_a: assert property ($changed(o_hrdata) |-> !$past(o_hreadyout) || $past(i_sys_rst))
    else $error("read data changed outside a read");
  chan_onehot_a: assert property ($onehot0(o_cmp1_minus_onehot) && $onehot0(o_cmp2_minus_onehot))
    else $error("minus select not one-hot");
  pkg_limit_a: assert property (!i_large_package [*3] |-> o_cmp1_minus_onehot[2:1] == 2'h0
    && o_cmp2_minus_onehot[2:1] == 2'h0 && !o_cmp1_minus_onehot[2])
    else $error("absent channel selected");
  power_chan_a: assert property ((o_cmp1_power |-> o_cmp1_minus_onehot != 4'h0)
    and (o_cmp2_power |-> o_cmp2_minus_onehot != 4'h0))
    else $error("comparator on without channel");
  resp_okay_a: assert property (o_hresp == 1'b0)
    else $error("error response seen");
endmodule
bind cmpc_top cmpc_checker u_cmpc_checker (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_large_package(i_large_package), .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
  .o_cmp1_power(o_cmp1_power), .o_cmp2_power(o_cmp2_power), .o_cmp1_minus_onehot(o_cmp1_minus_onehot),
  .o_cmp2_minus_onehot(o_cmp2_minus_onehot), .o_irq(o_irq));

/* cmpc_top_tb.sv */
`timescale 1ns/1ps
`include "cmpc_map.svh"
module cmpc_top_tb;
  logic clk = 0;
  logic rst = 1;
  logic pkg = 1;
  logic hsel = 0;
  logic [31:0] ha = 0;
  logic [1:0] ht = 0;
  logic hw = 0;
  logic [31:0] hwd = 0;
  logic r1 = 0;
  logic r2 = 0;
  logic rdy, resp, p1, p2, ps1, ps2, f1, f1e, f2, f2e, irq;
  logic [31:0] hrd;
  logic [3:0] m1, m2;
  int err_total = 0;
  int cmp_count = 0;
  int e;
  cmpc_top u_cmpc_top (.i_clk(clk), .i_sys_rst(rst), .i_large_package(pkg), .i_hsel(hsel),
    .i_haddr(ha), .i_htrans(ht), .i_hwrite(hw), .i_hsize(3'h2), .i_hready(rdy), .i_hwdata(hwd),
    .i_cmp1_raw(r1), .i_cmp2_raw(r2), .o_hreadyout(rdy), .o_hresp(resp), .o_hrdata(hrd),
    .o_cmp1_power(p1), .o_cmp2_power(p2), .o_cmp1_plus_sel(ps1), .o_cmp2_plus_sel(ps2),
    .o_cmp1_minus_onehot(m1), .o_cmp2_minus_onehot(m2), .o_pin_f1_out(f1), .o_pin_f1_oe(f1e),
    .o_pin_f2_out(f2), .o_pin_f2_oe(f2e), .o_irq(irq));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, s, x);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    ha <= {24'h0, a};
    hw <= w;
    ht <= 2'h2;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    ht <= 2'h0;
    hsel <= 1'b0;
    hwd <= d;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(a, 1'b0, 32'h0);
    chk(hrd, x);
  endtask
  task automatic st;
    repeat (6) @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #50000;
    err_total++;
    report_and_stop();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(`CMPC_OFS_CTRL1, 32'h1F);
    rd(`CMPC_OFS_CTRL2, 32'h1F);
    chk(f1e, 32'h0);
    xfer(8'h20, 1'b1, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    $display("done reset");
    for (e = 0; e < 4; e++)
    begin
      xfer(`CMPC_OFS_CTRL1, 1'b1, 32'h80 | e);
      xfer(`CMPC_OFS_CTRL2, 1'b1, 32'h80 | e);
      st();
      chk(m1, (e == 2) ? 32'h0 : 32'h1 << e);
      chk(m2, 32'h1 << e);
      chk(p2, 32'h1);
      chk(ps2, 32'h0);
      chk(resp, 32'h0);
      chk(p1, e != 2);
    end
    pkg <= 1'b0;
    xfer(`CMPC_OFS_CTRL1, 1'b1, 32'h81);
    st();
    chk(m1, 32'h0);
    chk(p1, 32'h0);
    pkg <= 1'b1;
    xfer(`CMPC_OFS_CTRL1, 1'b1, 32'h84);
    st();
    chk(ps1, 32'h1);
    $display("done channels");
    xfer(`CMPC_OFS_CTRL2, 1'b1, 32'h0);
    r1 <= 1'b1;
    xfer(`CMPC_OFS_CTRL1, 1'b1, 32'h80);
    st();
    rd(`CMPC_OFS_RESULT, 32'h1);
    xfer(`CMPC_OFS_CTRL1, 1'b1, 32'hA0);
    st();
    rd(`CMPC_OFS_RESULT, 32'h0);
    xfer(`CMPC_OFS_RESULT, 1'b1, 32'h3);
    rd(`CMPC_OFS_RESULT, 32'h0);
    xfer(`CMPC_OFS_CTRL1, 1'b1, 32'h0);
    st();
    rd(`CMPC_OFS_RESULT, 32'h0);
    r1 <= 1'b0;
    $display("done result");
    xfer(`CMPC_OFS_FLAG, 1'b1, 32'h0);
    for (e = 0; e < 4; e++)
    begin
      xfer(`CMPC_OFS_CTRL1, 1'b1, 32'h80 | (e << 3));
      st();
      rd(`CMPC_OFS_FLAG, (e == 3) ? 32'h20 : 32'h0);
      xfer(`CMPC_OFS_FLAG, 1'b1, 32'h0);
      r1 <= 1'b1;
      st();
      rd(`CMPC_OFS_FLAG, e[0] ? 32'h20 : 32'h0);
      r1 <= 1'b0;
      st();
      rd(`CMPC_OFS_FLAG, (e != 0) ? 32'h20 : 32'h0);
      xfer(`CMPC_OFS_FLAG, 1'b1, 32'h0);
    end
    $display("done edges");
    xfer(`CMPC_OFS_FLAG, 1'b1, 32'h60);
    rd(`CMPC_OFS_FLAG, 32'h60);
    chk(irq, 32'h0);
    xfer(`CMPC_OFS_ENABLE, 1'b1, 32'h20);
    for (e = 1; e < 4; e++)
    begin
      xfer(`CMPC_OFS_IRQCTL, 1'b1, e << 6);
      st();
      chk(irq, e == 3);
    end
    xfer(`CMPC_OFS_ENABLE, 1'b1, 32'h0);
    st();
    chk(irq, 32'h0);
    xfer(`CMPC_OFS_FLAG, 1'b1, 32'h0);
    rd(`CMPC_OFS_FLAG, 32'h0);
    $display("done irq");
    xfer(`CMPC_OFS_CTRL1, 1'b1, 32'h0);
    xfer(`CMPC_OFS_PDIR, 1'b1, 32'h0);
    xfer(`CMPC_OFS_PLAT, 1'b1, 32'h2);
    st();
    chk(f1e, 32'h1);
    chk(f2e, 32'h1);
    chk(f1, 32'h1);
    chk(f2, 32'h0);
    xfer(`CMPC_OFS_CTRL1, 1'b1, 32'hC0);
    st();
    chk(f1, 32'h0);
    r1 <= 1'b1;
    st();
    chk(f1, 32'h1);
    chk(f1e, 32'h1);
    xfer(`CMPC_OFS_CTRL1, 1'b1, 32'h88);
    xfer(`CMPC_OFS_FLAG, 1'b1, 32'h0);
    xfer(`CMPC_OFS_CTRL1, 1'b1, 32'h08);
    st();
    xfer(`CMPC_OFS_CTRL1, 1'b1, 32'h88);
    st();
    rd(`CMPC_OFS_FLAG, 32'h0);
    $display("done pins");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`CMPC_OFS_CTRL1, 32'h1F);
    chk(p1, 32'h0);
    chk(f1e, 32'h0);
    $display("done rerun reset");
    report_and_stop();
  end
endmodule
